// ---- byte_feeder.sv ----
`timescale 1ns/1ps
`default_nettype none

module byte_feeder (
  input wire logic sys_clk, // Clock
  input wire logic go, // Start a sequence
  input wire logic [1:0] nbytes, // Bytes in sequence
  input wire logic [15:0] seq, // First byte on top
  input wire logic byte_ready_reg, // Device takes byte
  output logic byte_valid, // Byte offered
  output logic [7:0] byte_data // Byte on offer
);
  logic [15:0] sh;
  logic [1:0] left;
  logic taken;
  logic start;
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
  end
  always @(posedge sys_clk) begin
    taken <= byte_valid && byte_ready_reg;
    start <= go;
  end
  // Released data is inverted so a stale byte never looks valid
  always @(negedge sys_clk) begin
    if (start) begin
      sh <= seq << 8;
      left <= nbytes - 2'h1;
      byte_valid <= 1'b1;
      byte_data <= seq[15:8];
    end else if (taken && left != 2'h0) begin
      left <= left - 2'h1;
      byte_data <= sh[15:8];
    end else if (taken) begin
      byte_valid <= 1'b0;
      byte_data <= ~byte_data;
    end
  end
endmodule : byte_feeder

`default_nettype wire

// ---- cycle_calc.sv ----
`timescale 1ns/1ps
`default_nettype none

module cycle_calc import decode_pkg::*; (
  input wire logic sys_clk,                // Processor clock
  input wire logic rst_n,                  // Synchronous reset
  input wire decoded_s dec,                // Decoded instruction
  input wire logic narrow_bus,             // 1 for byte-wide bus variant
  input wire logic [15:0] count_value,     // Repeat count
  output logic [CYC_W-1:0] cycles_reg      // Total clock cycles
);

  logic [7:0] fixed;
  logic [7:0] per;
  logic [1:0] xfers;
  logic [CYC_W-1:0] elems;
  logic [CYC_W-1:0] cycles_next;

  always_comb begin
    fixed = 8'h00;
    per = 8'h00;
    xfers = 2'h0;
    case (dec.op)
      OP_XOR_RM, OP_INVERT: begin
        fixed = dec.mem_operand ? C_LOGIC_MEM : C_LOGIC_REG;
        xfers = dec.mem_operand ? 2'h2 : 2'h0;
      end
      OP_XOR_IMM: begin
        fixed = dec.mem_operand ? C_IMM_MEM : C_IMM_REG;
        xfers = dec.mem_operand ? 2'h2 : 2'h0;
      end
      OP_XOR_ACC: fixed = dec.word ? C_ACC_WORD : C_ACC_BYTE;
      OP_STR_MOVE: begin
        fixed = dec.repeated ? C_REP_MOVE_BASE : C_MOVE;
        per = dec.repeated ? C_REP_MOVE_PER : 8'h00;
        xfers = 2'h2;
      end
      OP_STR_CMP: begin
        fixed = dec.repeated ? C_REP_CMP_BASE : C_CMP;
        per = dec.repeated ? C_REP_CMP_PER : 8'h00;
        xfers = 2'h2;
      end
      OP_STR_SCAN: begin
        fixed = dec.repeated ? C_REP_SCAN_BASE : C_SCAN;
        per = dec.repeated ? C_REP_SCAN_PER : 8'h00;
        xfers = 2'h1;
      end
      OP_STR_LOAD: begin
        fixed = dec.repeated ? C_REP_LOAD_BASE : C_LOAD;
        per = dec.repeated ? C_REP_LOAD_PER : 8'h00;
        xfers = 2'h1;
      end
      OP_STR_STORE: begin
        fixed = dec.repeated ? C_REP_STORE_BASE : C_STORE;
        per = dec.repeated ? C_REP_STORE_PER : 8'h00;
        xfers = 2'h1;
      end
      OP_STR_IN, OP_STR_OUT: begin
        // Single port transfers carry no word penalty, repeated ones do
        fixed = dec.repeated ? C_REP_PORT_BASE : C_PORT;
        per = dec.repeated ? C_REP_PORT_PER : 8'h00;
        xfers = dec.repeated ? 2'h1 : 2'h0;
      end
      OP_JMP_NEAR, OP_JMP_FAR: fixed = C_JMP_DIRECT;
      OP_JMP_IND: begin
        if (!dec.mem_operand) begin
          fixed = C_JMP_IND_REG;
        end else begin
          fixed = narrow_bus ? C_JMP_IND_MEM_NARROW : C_JMP_IND_MEM_WIDE;
        end
      end
      OP_JMP_FAR_IND: fixed = narrow_bus ? C_JMP_FAR_IND_NARROW : C_JMP_FAR_IND_WIDE;
      default: fixed = 8'h00;
    endcase
  end

  always_comb begin
    elems = dec.repeated ? {8'h00, count_value} : 24'h000001;
    cycles_next = {16'h0000, fixed} + CYC_W'({16'h0000, per} * elems);
    if (narrow_bus && dec.word) begin
      cycles_next = cycles_next + CYC_W'({22'h000000, xfers} * C_WORD_XFER_ADD * elems);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cycles_reg <= '0;
    end else begin
      cycles_reg <= cycles_next;
    end
  end

endmodule : cycle_calc

`default_nettype wire

// ---- decode_pkg.sv ----
package decode_pkg;

  // ------------------------------------------------------------
  // Opcode patterns (upper seven bits, w or z in bit 0; XOR_RM_PAT upper six, d and w below; jump and group 5 codes whole bytes)
  // ------------------------------------------------------------
  localparam logic [5:0] XOR_RM_PAT = 6'h0C;        // 001100dw
  localparam logic [6:0] XOR_IMM_PAT = 7'h40;       // 1000000w
  localparam logic [6:0] XOR_ACC_PAT = 7'h1A;       // 0011010w
  localparam logic [6:0] GROUP3_PAT = 7'h7B;        // 1111011w
  localparam logic [6:0] STR_MOVE_PAT = 7'h52;      // 1010010w
  localparam logic [6:0] STR_CMP_PAT = 7'h53;       // 1010011w
  localparam logic [6:0] STR_SCAN_PAT = 7'h57;      // 1010111w
  localparam logic [6:0] STR_LOAD_PAT = 7'h56;      // 1010110w
  localparam logic [6:0] STR_STORE_PAT = 7'h55;     // 1010101w
  localparam logic [6:0] STR_IN_PAT = 7'h36;        // 0110110w
  localparam logic [6:0] STR_OUT_PAT = 7'h37;       // 0110111w
  localparam logic [6:0] REP_PAT = 7'h79;           // 1111001z
  localparam logic [7:0] JMP_NEAR_CODE = 8'hEB;
  localparam logic [7:0] JMP_FAR_CODE = 8'hEA;
  localparam logic [7:0] GROUP5_CODE = 8'hFF;
  localparam logic [2:0] EXT_XOR = 3'h6;
  localparam logic [2:0] EXT_INVERT = 3'h2;
  localparam logic [2:0] EXT_JMP_IND = 3'h4;
  localparam logic [2:0] EXT_JMP_FAR_IND = 3'h5;
  localparam logic [1:0] MOD_REGISTER = 2'h3;

  // ------------------------------------------------------------
  // Cycle figures
  // ------------------------------------------------------------
  localparam int CYC_W = 24;
  localparam logic [7:0] C_LOGIC_REG = 8'h03;
  localparam logic [7:0] C_LOGIC_MEM = 8'h0A;
  localparam logic [7:0] C_IMM_REG = 8'h04;
  localparam logic [7:0] C_IMM_MEM = 8'h10;
  localparam logic [7:0] C_ACC_BYTE = 8'h03;
  localparam logic [7:0] C_ACC_WORD = 8'h04;
  localparam logic [7:0] C_MOVE = 8'h0E;
  localparam logic [7:0] C_CMP = 8'h16;
  localparam logic [7:0] C_SCAN = 8'h0F;
  localparam logic [7:0] C_LOAD = 8'h0C;
  localparam logic [7:0] C_STORE = 8'h0A;
  localparam logic [7:0] C_PORT = 8'h0E;
  localparam logic [7:0] C_REP_MOVE_BASE = 8'h08;
  localparam logic [7:0] C_REP_MOVE_PER = 8'h08;
  localparam logic [7:0] C_REP_CMP_BASE = 8'h05;
  localparam logic [7:0] C_REP_CMP_PER = 8'h16;
  localparam logic [7:0] C_REP_SCAN_BASE = 8'h05;
  localparam logic [7:0] C_REP_SCAN_PER = 8'h0F;
  localparam logic [7:0] C_REP_LOAD_BASE = 8'h06;
  localparam logic [7:0] C_REP_LOAD_PER = 8'h0B;
  localparam logic [7:0] C_REP_STORE_BASE = 8'h06;
  localparam logic [7:0] C_REP_STORE_PER = 8'h09;
  localparam logic [7:0] C_REP_PORT_BASE = 8'h08;
  localparam logic [7:0] C_REP_PORT_PER = 8'h08;
  localparam logic [7:0] C_JMP_DIRECT = 8'h0E;
  localparam logic [7:0] C_JMP_IND_REG = 8'h0B;
  localparam logic [7:0] C_JMP_IND_MEM_WIDE = 8'h11;
  localparam logic [7:0] C_JMP_IND_MEM_NARROW = 8'h15;
  localparam logic [7:0] C_JMP_FAR_IND_WIDE = 8'h1A;
  localparam logic [7:0] C_JMP_FAR_IND_NARROW = 8'h22;
  localparam logic [7:0] C_WORD_XFER_ADD = 8'h04;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE, OP_XOR_RM, OP_XOR_IMM, OP_XOR_ACC, OP_INVERT,
    OP_STR_MOVE, OP_STR_CMP, OP_STR_SCAN, OP_STR_LOAD, OP_STR_STORE,
    OP_STR_IN, OP_STR_OUT, OP_JMP_NEAR, OP_JMP_IND, OP_JMP_FAR, OP_JMP_FAR_IND
  } op_e;

  typedef struct packed {
    op_e op;
    logic word;          // 1 word, 0 byte
    logic reg_is_dest;   // Direction bit
    logic mem_operand;
    logic repeated;
    logic while_equal;   // Prefix z bit
  } decoded_s;

endpackage : decode_pkg

// ---- decode_props.sv ----
`timescale 1ns/1ps
`default_nettype none

module decode_props import decode_pkg::*; (
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic byte_valid, // Byte offered
  input wire logic [7:0] byte_data, // Byte
  input wire logic narrow_bus, // Bus variant
  input wire logic [15:0] count_value, // Count
  input wire logic byte_ready_reg, // Ready
  input wire decoded_s decoded_reg, // Decoded
  input wire logic [CYC_W-1:0] cycles_out_reg, // Cycles
  input wire logic decode_valid_reg, // Decode pulse
  input wire logic illegal_reg, // Illegal pulse
  input wire logic busy_reg, // Executing
  input wire logic done_reg // Done pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [CYC_W-1:0] busy_cnt;
  logic dv_single;
  assign dv_single = decode_valid_reg && !decoded_reg.repeated;
  // Busy length counted here, so a stuck state shows up
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !busy_reg) busy_cnt <= '0;
    else busy_cnt <= busy_cnt + 1'b1;
  end
  property p_move_lat;
    byte_valid && byte_ready_reg && byte_data == 8'hA5 |-> ##3 decode_valid_reg;
  endproperty
  a_move_lat: assert property (p_move_lat) else $error("decode late");
  property p_busy_start;
    $rose(busy_reg) |-> decode_valid_reg;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy start");
  property p_busy_len;
    $fell(busy_reg) |-> busy_cnt == cycles_out_reg && done_reg;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length");
  property p_done;
    done_reg |-> byte_ready_reg ##1 !done_reg;
  endproperty
  a_done: assert property (p_done) else $error("done pulse");
  property p_refuse;
    busy_reg |-> !byte_ready_reg;
  endproperty
  a_refuse: assert property (p_refuse) else $error("ready while busy");
  property p_valid;
    decode_valid_reg |-> busy_reg ##1 !decode_valid_reg;
  endproperty
  a_valid: assert property (p_valid) else $error("decode pulse");
  property p_illegal;
    illegal_reg |-> !decode_valid_reg && !busy_reg ##1 !illegal_reg;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal pulse");
  property p_port;
    dv_single && decoded_reg.op inside {OP_STR_IN, OP_STR_OUT} |-> cycles_out_reg == C_PORT;
  endproperty
  a_port: assert property (p_port) else $error("port cycles");
  property p_move;
    dv_single && decoded_reg.op == OP_STR_MOVE
      |-> cycles_out_reg == C_MOVE + ((narrow_bus && decoded_reg.word) ? 8 : 0);
  endproperty
  a_move: assert property (p_move) else $error("move cycles");
  property p_rep_move;
    decode_valid_reg && decoded_reg.repeated && decoded_reg.op == OP_STR_MOVE && !narrow_bus
      |-> cycles_out_reg == 8 + 8 * count_value;
  endproperty
  a_rep_move: assert property (p_rep_move) else $error("repeat cycles");
  property p_jump;
    decode_valid_reg && decoded_reg.op inside {OP_JMP_NEAR, OP_JMP_FAR}
      |-> cycles_out_reg == C_JMP_DIRECT && !decoded_reg.word;
  endproperty
  a_jump: assert property (p_jump) else $error("jump cycles");
  c_rep: cover property (decode_valid_reg && decoded_reg.repeated);
  c_ill: cover property (illegal_reg);
  c_done: cover property (done_reg && narrow_bus);
endmodule : decode_props

`default_nettype wire

// ---- instr_decode.sv ----
// What this block does
// - Exclusive-or: register form 3/10, immediate form ext 110 4/16, accumulator 3/4.
// - 1111011w with ext 010 is invert, 3 register or 10 memory cycles.
// - 1010010w is single string move, 14 cycles.
// - 1010011w is single string compare, flags only, 22 cycles.
// - 1010111w is single string scan against accumulator, 15 cycles.
// - 1010110w is single string load into accumulator, 12 cycles.
// - 1010101w is single string store from accumulator, 10 cycles.
// - 0110110w is single port string input, 14 cycles, no word penalty.
// - 0110111w is single port string output, 14 cycles.
// - Repeat prefix: move 8+8n, load 6+11n, store 6+9n cycles.
// - Prefix 1111001z: z picks while-equal or while-unequal; compare 5+22n, scan 5+15n.
// - Repeated port input and output each take 8+8n cycles.
// - Jumps: EB/EA 14, FF ext 100 11/17 or 11/21, ext 101 26/34.
// - Narrow bus word operations add 4 cycles per memory transfer, except single port input and output.
`timescale 1ns/1ps
`default_nettype none

module instr_decode import decode_pkg::*; (
  input wire logic sys_clk,                // Processor clock
  input wire logic rst_n,                  // Synchronous reset, active low
  input wire logic byte_valid,             // Instruction byte offered
  input wire logic [7:0] byte_data,        // Instruction byte
  input wire logic narrow_bus,             // 1 for byte-wide bus variant
  input wire logic [15:0] count_value,     // Count register contents
  output logic byte_ready_reg,             // Byte will be taken
  output decoded_s decoded_reg,            // Decoded instruction
  output logic [CYC_W-1:0] cycles_out_reg, // Total execution cycles
  output logic decode_valid_reg,           // Pulse: decoded and cycles valid
  output logic illegal_reg,                // Pulse: byte sequence not handled
  output logic busy_reg,                   // Executing
  output logic done_reg                    // Pulse: first cycle after the last execution cycle
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [2:0] {ST_OPCODE, ST_MODRM, ST_CALC, ST_LOAD, ST_EXEC} state_e;

  state_e state_reg;
  state_e state_next;
  decoded_s dec_reg;
  decoded_s dec_next;
  logic [7:0] first_reg;
  logic [CYC_W-1:0] calc_cycles;
  logic [CYC_W-1:0] remain_reg;
  logic illegal_next;
  logic take;

  assign take = byte_valid && byte_ready_reg;

  // ------------------------------------------------------------
  // Cycle figures, one register stage behind the decode
  // ------------------------------------------------------------
  cycle_calc u_calc (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .dec(dec_reg),
    .narrow_bus(narrow_bus),
    .count_value(count_value),
    .cycles_reg(calc_cycles)
  );

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    dec_next = dec_reg;
    illegal_next = 1'b0;
    case (state_reg)
      ST_OPCODE: begin
        if (take) begin
          dec_next.word = byte_data[0];
          dec_next.reg_is_dest = 1'b0;
          dec_next.mem_operand = 1'b0;
          dec_next.op = OP_NONE;
          state_next = ST_CALC;
          if (byte_data[7:1] == REP_PAT && !dec_reg.repeated) begin
            dec_next.repeated = 1'b1;
            dec_next.while_equal = byte_data[0];
            state_next = ST_OPCODE;
          end else if (byte_data[7:1] == STR_MOVE_PAT) begin
            dec_next.op = OP_STR_MOVE;
          end else if (byte_data[7:1] == STR_CMP_PAT) begin
            dec_next.op = OP_STR_CMP;
          end else if (byte_data[7:1] == STR_SCAN_PAT) begin
            dec_next.op = OP_STR_SCAN;
          end else if (byte_data[7:1] == STR_LOAD_PAT) begin
            dec_next.op = OP_STR_LOAD;
          end else if (byte_data[7:1] == STR_STORE_PAT) begin
            dec_next.op = OP_STR_STORE;
          end else if (byte_data[7:1] == STR_IN_PAT) begin
            dec_next.op = OP_STR_IN;
          end else if (byte_data[7:1] == STR_OUT_PAT) begin
            dec_next.op = OP_STR_OUT;
          end else if (dec_reg.repeated) begin
            // A prefix before a non-string opcode is not handled here
            illegal_next = 1'b1;
            dec_next.repeated = 1'b0;
            dec_next.while_equal = 1'b0;
            state_next = ST_OPCODE;
          end else if (byte_data[7:2] == XOR_RM_PAT) begin
            dec_next.op = OP_XOR_RM;
            dec_next.reg_is_dest = byte_data[1];
            state_next = ST_MODRM;
          end else if (byte_data[7:1] == XOR_ACC_PAT) begin
            dec_next.op = OP_XOR_ACC;
          end else if (byte_data[7:1] == XOR_IMM_PAT || byte_data[7:1] == GROUP3_PAT
                       || byte_data == GROUP5_CODE) begin
            state_next = ST_MODRM;
          end else if (byte_data == JMP_NEAR_CODE) begin
            dec_next.op = OP_JMP_NEAR;
            dec_next.word = 1'b0;
          end else if (byte_data == JMP_FAR_CODE) begin
            dec_next.op = OP_JMP_FAR;
            dec_next.word = 1'b0;
          end else begin
            illegal_next = 1'b1;
            state_next = ST_OPCODE;
          end
        end
      end
      ST_MODRM: begin
        if (take) begin
          dec_next.mem_operand = (byte_data[7:6] != MOD_REGISTER);
          state_next = ST_CALC;
          if (dec_reg.op == OP_XOR_RM) begin
            dec_next.op = OP_XOR_RM;
          end else if (first_reg[7:1] == XOR_IMM_PAT && byte_data[5:3] == EXT_XOR) begin
            dec_next.op = OP_XOR_IMM;
          end else if (first_reg[7:1] == GROUP3_PAT && byte_data[5:3] == EXT_INVERT) begin
            dec_next.op = OP_INVERT;
          end else if (first_reg == GROUP5_CODE && byte_data[5:3] == EXT_JMP_IND) begin
            dec_next.op = OP_JMP_IND;
            dec_next.word = 1'b0;
          end else if (first_reg == GROUP5_CODE && byte_data[5:3] == EXT_JMP_FAR_IND
                       && byte_data[7:6] != MOD_REGISTER) begin
            dec_next.op = OP_JMP_FAR_IND;
            dec_next.word = 1'b0;
          end else begin
            illegal_next = 1'b1;
            state_next = ST_OPCODE;
          end
        end
      end
      ST_CALC: state_next = ST_LOAD;
      ST_LOAD: state_next = ST_EXEC;
      ST_EXEC: begin
        if (remain_reg <= 24'h000001) begin
          state_next = ST_OPCODE;
          dec_next.repeated = 1'b0;
          dec_next.while_equal = 1'b0;
        end
      end
      default: state_next = ST_OPCODE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= ST_OPCODE;
      dec_reg <= '{op: OP_NONE, default: 1'b0};
    end else begin
      state_reg <= state_next;
      dec_reg <= dec_next;
    end
  end

  // First byte kept so the modifier byte can pick the group member
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      first_reg <= 8'h00;
    end else if (take && state_reg == ST_OPCODE) begin
      first_reg <= byte_data;
    end
  end

  // ------------------------------------------------------------
  // Byte handshake
  // ------------------------------------------------------------
  // Ready follows the next state, so no byte past the last one is taken
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      byte_ready_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      byte_ready_reg <= (state_next == ST_OPCODE) || (state_next == ST_MODRM);
      illegal_reg <= illegal_next;
    end
  end

  // ------------------------------------------------------------
  // Execution timing
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      remain_reg <= '0;
      cycles_out_reg <= '0;
      decoded_reg <= '{op: OP_NONE, default: 1'b0};
      decode_valid_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      decode_valid_reg <= (state_reg == ST_LOAD);
      done_reg <= (state_reg == ST_EXEC) && (remain_reg <= 24'h000001);
      if (state_reg == ST_LOAD) begin
        remain_reg <= calc_cycles;
        cycles_out_reg <= calc_cycles;
        decoded_reg <= dec_reg;
        busy_reg <= 1'b1;
      end else if (state_reg == ST_EXEC) begin
        remain_reg <= remain_reg - 24'h000001;
        if (remain_reg <= 24'h000001) begin
          busy_reg <= 1'b0;
        end
      end
    end
  end

endmodule : instr_decode

`default_nettype wire

// ---- logic_string_branch_decode_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module logic_string_branch_decode_test;
  import decode_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic narrow_bus = 1'b0;
  logic [15:0] count_value = 16'h0000;
  logic go = 1'b0;
  logic [1:0] nbytes = 2'h1;
  logic [15:0] seq = 16'h0000;
  logic byte_valid, byte_ready_reg, decode_valid_reg, illegal_reg, busy_reg, done_reg;
  logic [7:0] byte_data;
  decoded_s decoded_reg;
  logic [CYC_W-1:0] cycles_out_reg;
  int error_cnt = 0;
  int total_checks = 0;
  always #5 sys_clk = ~sys_clk;
  instr_decode i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .byte_valid(byte_valid),
    .byte_data(byte_data), .narrow_bus(narrow_bus), .count_value(count_value),
    .byte_ready_reg(byte_ready_reg), .decoded_reg(decoded_reg),
    .cycles_out_reg(cycles_out_reg), .decode_valid_reg(decode_valid_reg),
    .illegal_reg(illegal_reg), .busy_reg(busy_reg), .done_reg(done_reg));
  byte_feeder i_feed (.sys_clk(sys_clk), .go(go), .nbytes(nbytes), .seq(seq),
    .byte_ready_reg(byte_ready_reg), .byte_valid(byte_valid), .byte_data(byte_data));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic wait_sig(ref logic s, input int lim);
    int k;
    k = 0;
    while (s !== 1'b1) begin
      if (k == lim) begin
        check(1'b0, "wait timed out");
        finish_test();
      end
      @(posedge sys_clk);
      #1;
      k++;
    end
  endtask : wait_sig

  task automatic send(input logic [15:0] b, input logic [1:0] nb, input logic [15:0] n,
    input logic nar);
    @(negedge sys_clk);
    seq = b;
    nbytes = nb;
    count_value = n;
    narrow_bus = nar;
    go = 1'b1;
    @(negedge sys_clk);
    go = 1'b0;
  endtask : send

  // Expected cycles come from the caller, worked out by hand
  task automatic run(input logic [15:0] b, input logic [1:0] nb, input logic [15:0] n,
    input logic nar, input op_e op, input logic w, input int cyc);
    int k;
    send(b, nb, n, nar);
    wait_sig(decode_valid_reg, 12);
    check(decoded_reg.op === op && decoded_reg.word === w, "decoded kind");
    check(cycles_out_reg === cyc[CYC_W-1:0], "cycle figure");
    k = 0;
    while (busy_reg === 1'b1 && k < 300) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    check(k == cyc && done_reg === 1'b1, "busy length");
    @(posedge sys_clk);
    #1;
    check(byte_ready_reg === 1'b1 && done_reg === 1'b0, "ready after done");
  endtask : run

  task automatic run_bad(input logic [15:0] b);
    send(b, 2'h2, 16'h0001, 1'b0);
    wait_sig(illegal_reg, 12);
    check(decode_valid_reg === 1'b0, "illegal decoded");
    wait_sig(byte_ready_reg, 40);
  endtask : run_bad

  task automatic t_logic();
    run(16'h33C0, 2, 0, 0, OP_XOR_RM, 1, 3);
    check(decoded_reg.reg_is_dest === 1'b1 && decoded_reg.mem_operand === 1'b0, "d bit");
    run(16'h3206, 2, 0, 0, OP_XOR_RM, 0, 10);
    check(decoded_reg.mem_operand === 1'b1, "memory operand");
    run(16'h81F0, 2, 0, 0, OP_XOR_IMM, 1, 4);
    run(16'h8036, 2, 0, 0, OP_XOR_IMM, 0, 16);
    run(16'h3400, 1, 0, 0, OP_XOR_ACC, 0, 3);
    run(16'hF7D0, 2, 0, 0, OP_INVERT, 1, 3);
    run(16'hF616, 2, 0, 0, OP_INVERT, 0, 10);
    $display("logic test done");
  endtask : t_logic

  task automatic t_string();
    run(16'hA500, 1, 0, 0, OP_STR_MOVE, 1, 14);
    check(decoded_reg.repeated === 1'b0, "single has repeat flag");
    run(16'hA600, 1, 0, 0, OP_STR_CMP, 0, 22);
    run(16'hAF00, 1, 0, 0, OP_STR_SCAN, 1, 15);
    run(16'hAC00, 1, 0, 0, OP_STR_LOAD, 0, 12);
    run(16'hAB00, 1, 0, 0, OP_STR_STORE, 1, 10);
    run(16'h6C00, 1, 0, 0, OP_STR_IN, 0, 14);
    run(16'h6F00, 1, 0, 0, OP_STR_OUT, 1, 14);
    $display("single string test done");
  endtask : t_string

  task automatic t_repeat();
    run(16'hF3A4, 2, 3, 0, OP_STR_MOVE, 0, 32);
    check(decoded_reg.repeated === 1'b1, "repeat flag");
    run(16'hF2A7, 2, 2, 0, OP_STR_CMP, 1, 49);
    check(decoded_reg.while_equal === 1'b0, "unequal prefix");
    run(16'hF3AE, 2, 1, 0, OP_STR_SCAN, 0, 20);
    check(decoded_reg.while_equal === 1'b1, "equal prefix");
    run(16'hF3AC, 2, 4, 0, OP_STR_LOAD, 0, 50);
    run(16'hF3AB, 2, 3, 0, OP_STR_STORE, 1, 33);
    run(16'hF36C, 2, 2, 0, OP_STR_IN, 0, 24);
    run(16'hF36F, 2, 0, 0, OP_STR_OUT, 1, 8);
    $display("repeat test done");
  endtask : t_repeat

  task automatic t_jump();
    run(16'hEB00, 1, 0, 0, OP_JMP_NEAR, 0, 14);
    run(16'hEA00, 1, 0, 0, OP_JMP_FAR, 0, 14);
    run(16'hFFE0, 2, 0, 0, OP_JMP_IND, 0, 11);
    run(16'hFF26, 2, 0, 0, OP_JMP_IND, 0, 17);
    run(16'hFF2E, 2, 0, 0, OP_JMP_FAR_IND, 0, 26);
    $display("jump test done");
  endtask : t_jump

  // Narrow bus: word memory transfers cost extra, single port input keeps 14, jump figures differ
  task automatic t_narrow();
    run(16'hA500, 1, 0, 1, OP_STR_MOVE, 1, 22);
    run(16'hA400, 1, 0, 1, OP_STR_MOVE, 0, 14);
    run(16'hF3A5, 2, 2, 1, OP_STR_MOVE, 1, 40);
    run(16'h6D00, 1, 0, 1, OP_STR_IN, 1, 14);
    run(16'h3306, 2, 0, 1, OP_XOR_RM, 1, 18);
    run(16'hFF26, 2, 0, 1, OP_JMP_IND, 0, 21);
    run(16'hFF2E, 2, 0, 1, OP_JMP_FAR_IND, 0, 34);
    $display("narrow bus test done");
  endtask : t_narrow

  task automatic t_illegal();
    run_bad(16'hF333);
    run_bad(16'hFFE8);
    run_bad(16'hF6D8);
    run_bad(16'hF3F3);
    $display("illegal test done");
  endtask : t_illegal

  initial begin
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    wait_sig(byte_ready_reg, 5);
    t_logic();
    t_string();
    t_repeat();
    t_jump();
    t_narrow();
    t_illegal();
    run(16'hA500, 1, 0, 0, OP_STR_MOVE, 1, 14);
    finish_test();
  end
endmodule : logic_string_branch_decode_test

bind instr_decode decode_props i_props (.sys_clk(sys_clk), .rst_n(rst_n),
  .byte_valid(byte_valid), .byte_data(byte_data), .narrow_bus(narrow_bus),
  .count_value(count_value), .byte_ready_reg(byte_ready_reg), .decoded_reg(decoded_reg),
  .cycles_out_reg(cycles_out_reg), .decode_valid_reg(decode_valid_reg),
  .illegal_reg(illegal_reg), .busy_reg(busy_reg), .done_reg(done_reg));

`default_nettype wire
